// ==== fp_load_decode_ea.sv ====
// decode and sequencing of quad-indexed and single-precision float loads
// assumes the pipeline holds an instruction until accepted and that the
// load port answers each request with a data or fault pulse
//
// Functional notes
// - primary 31 with extended 791 is quad-indexed; address base+index or index
// - quad fills target then next register; after register 31 comes 0
// - quad-indexed load never writes status/control or condition field 0
// - primary 48 loads a single word, widens it, writes target
// - displacement address is base plus sign-extended displacement, or displacement alone
// - primary 49 writes address back to nonzero base unless the access faulted
// - primary 31 with extended 567 is update-indexed; address base+index or index
// - update-indexed writes address to nonzero base only without fault
// - displacement and update loads never touch status/control or condition field 0
// - update-indexed single load never alters status/control register
`timescale 1ns/1ps
module fp_load_decode_ea
   import fp_load_pkg::*;
(
   input  wire logic        sys_clk_in,
   input  wire logic        rstn_in,
   input  wire logic        instr_valid_in,
   input  wire logic [31:0] instr_word_in,
   input  wire logic [31:0] base_value_in,
   input  wire logic [31:0] index_value_in,
   input  wire logic        mem_data_valid_in,
   input  wire logic [63:0] mem_data_in,
   input  wire logic        mem_fault_in,
   output logic             instr_ready_out,
   output logic             instr_illegal_out,
   output logic             mem_req_out,
   output logic [31:0]      mem_addr_out,
   output logic             mem_single_out,
   output logic             freg_we_out,
   output logic [4:0]       freg_addr_out,
   output logic [63:0]      freg_data_out,
   output logic             ireg_we_out,
   output logic [4:0]       ireg_addr_out,
   output logic [31:0]      ireg_data_out,
   output logic             done_out
);
   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   // zero base field means no base register, used by every form
   function automatic logic [31:0] form_address(input logic [4:0] base_f,
                                                input logic [31:0] base_v,
                                                input logic [31:0] offs);
      form_address = (base_f == 5'h00) ? offs : base_v + offs;
   endfunction

   // -------------------------------------------------------------
   // decode
   // -------------------------------------------------------------
   logic [5:0]    primary;
   logic [9:0]    xop;
   logic [4:0]    tgt_f;
   logic [4:0]    base_f;
   logic [31:0]   disp_ext;
   logic          dec_ok;
   load_kind_type dec_kind;
   logic [31:0]   dec_addr;

   always_comb begin
      primary  = instr_word_in[PRIMARY_MSB -: 6];
      xop      = instr_word_in[XOP_LSB +: 10];
      tgt_f    = instr_word_in[TARGET_LSB +: 5];
      base_f   = instr_word_in[BASE_LSB +: 5];
      disp_ext = {{16{instr_word_in[15]}}, instr_word_in[15:0]};
      dec_ok   = 1'b1;
      dec_kind = K_SINGLE;
      dec_addr = form_address(base_f, base_value_in, disp_ext);
      if (primary == OP_PRIMARY_EXT && xop == XOP_LOAD_QUAD_X) begin
         dec_kind = K_QUAD_X;
         dec_addr = form_address(base_f, base_value_in, index_value_in);
      end else if (primary == OP_PRIMARY_EXT && xop == XOP_LOAD_SU_X) begin
         dec_kind = K_SINGLE_UX;
         dec_addr = form_address(base_f, base_value_in, index_value_in);
      end else if (primary == OP_LOAD_SINGLE) begin
         dec_kind = K_SINGLE;
      end else if (primary == OP_LOAD_SINGLE_U) begin
         dec_kind = K_SINGLE_U;
      end else begin
         dec_ok = 1'b0;
      end
   end

   // -------------------------------------------------------------
   // widener
   // -------------------------------------------------------------
   fp_load_mem_if cvt_bus ();
   assign cvt_bus.single_word = mem_data_in[31:0];
   fp_single_widen u_widen (
      .cvt (cvt_bus.widen_side)
   );

   // -------------------------------------------------------------
   // sequencer state
   // -------------------------------------------------------------
   load_state_type state_ff, nxt_state;
   load_kind_type  kind_ff, nxt_kind;
   logic [4:0]     tgt_ff, nxt_tgt;
   logic [4:0]     base_ff, nxt_base;
   logic [31:0]    addr_ff, nxt_addr;
   logic [63:0]    first_ff, nxt_first;
   logic           ready_ff, nxt_ready;
   logic           illegal_ff, nxt_illegal;
   logic           req_ff, nxt_req;
   logic [31:0]    maddr_ff, nxt_maddr;
   logic           msingle_ff, nxt_msingle;
   logic           fwe_ff, nxt_fwe;
   logic [4:0]     faddr_ff, nxt_faddr;
   logic [63:0]    fdata_ff, nxt_fdata;
   logic           iwe_ff, nxt_iwe;
   logic [4:0]     iaddr_ff, nxt_iaddr;
   logic [31:0]    idata_ff, nxt_idata;
   logic           done_ff, nxt_done;

   // one instruction at a time; the quad form issues two doubleword reads and
   // holds the first until the second arrives so a fault can cancel both writes
   always_comb begin
      nxt_state   = state_ff;
      nxt_kind    = kind_ff;
      nxt_tgt     = tgt_ff;
      nxt_base    = base_ff;
      nxt_addr    = addr_ff;
      nxt_first   = first_ff;
      nxt_ready   = 1'b0;
      nxt_illegal = 1'b0;
      nxt_req     = 1'b0;
      nxt_maddr   = maddr_ff;
      nxt_msingle = msingle_ff;
      nxt_fwe     = 1'b0;
      nxt_faddr   = faddr_ff;
      nxt_fdata   = fdata_ff;
      nxt_iwe     = 1'b0;
      nxt_iaddr   = iaddr_ff;
      nxt_idata   = idata_ff;
      nxt_done    = 1'b0;
      unique case (state_ff)
         ST_IDLE: begin
            if (instr_valid_in && !ready_ff) begin
               nxt_ready = 1'b1;
               if (!dec_ok) begin
                  nxt_illegal = 1'b1;
                  nxt_done    = 1'b1;
               end else begin
                  nxt_kind    = dec_kind;
                  nxt_tgt     = tgt_f;
                  nxt_base    = base_f;
                  nxt_addr    = dec_addr;
                  nxt_req     = 1'b1;
                  nxt_maddr   = dec_addr;
                  nxt_msingle = (dec_kind != K_QUAD_X);
                  nxt_state   = ST_FIRST;
               end
            end
         end
         ST_FIRST: begin
            if (mem_fault_in) begin
               nxt_done  = 1'b1;
               nxt_state = ST_IDLE;
            end else if (mem_data_valid_in) begin
               if (kind_ff == K_QUAD_X) begin
                  nxt_first = mem_data_in;
                  nxt_req   = 1'b1;
                  nxt_maddr = addr_ff + QUAD_SECOND_OFS;
                  nxt_state = ST_SECOND;
               end else begin
                  nxt_fwe   = 1'b1;
                  nxt_faddr = tgt_ff;
                  nxt_fdata = cvt_bus.double_word;
                  // update forms write back only for a nonzero base
                  nxt_iwe   = (kind_ff != K_SINGLE) && (base_ff != 5'h00);
                  nxt_iaddr = base_ff;
                  nxt_idata = addr_ff;
                  nxt_done  = 1'b1;
                  nxt_state = ST_DONE;
               end
            end
         end
         ST_SECOND: begin
            if (mem_fault_in) begin
               nxt_done  = 1'b1;
               nxt_state = ST_IDLE;
            end else if (mem_data_valid_in) begin
               nxt_fwe   = 1'b1;
               nxt_faddr = tgt_ff;
               nxt_fdata = first_ff;
               nxt_state = ST_DONE;
            end
         end
         ST_DONE: begin
            // second register write of the quad form, wrapping 31 to 0
            if (kind_ff == K_QUAD_X && !done_ff) begin
               nxt_fwe   = 1'b1;
               nxt_faddr = (tgt_ff == LAST_FREG) ? 5'h00 : tgt_ff + 5'h01;
               nxt_fdata = mem_data_in;
               nxt_done  = 1'b1;
               nxt_state = ST_IDLE;
            end else begin
               nxt_state = ST_IDLE;
            end
         end
      endcase
   end

   // note: no status/control or condition-field port exists, so these loads
   // cannot affect them
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_ff   <= ST_IDLE;
         kind_ff    <= K_SINGLE;
         tgt_ff     <= 5'h00;
         base_ff    <= 5'h00;
         addr_ff    <= 32'h0;
         first_ff   <= 64'h0;
         ready_ff   <= 1'b0;
         illegal_ff <= 1'b0;
         req_ff     <= 1'b0;
         maddr_ff   <= 32'h0;
         msingle_ff <= 1'b0;
         fwe_ff     <= 1'b0;
         faddr_ff   <= 5'h00;
         fdata_ff   <= 64'h0;
         iwe_ff     <= 1'b0;
         iaddr_ff   <= 5'h00;
         idata_ff   <= 32'h0;
         done_ff    <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         kind_ff    <= nxt_kind;
         tgt_ff     <= nxt_tgt;
         base_ff    <= nxt_base;
         addr_ff    <= nxt_addr;
         first_ff   <= nxt_first;
         ready_ff   <= nxt_ready;
         illegal_ff <= nxt_illegal;
         req_ff     <= nxt_req;
         maddr_ff   <= nxt_maddr;
         msingle_ff <= nxt_msingle;
         fwe_ff     <= nxt_fwe;
         faddr_ff   <= nxt_faddr;
         fdata_ff   <= nxt_fdata;
         iwe_ff     <= nxt_iwe;
         iaddr_ff   <= nxt_iaddr;
         idata_ff   <= nxt_idata;
         done_ff    <= nxt_done;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign instr_ready_out   = ready_ff;
   assign instr_illegal_out = illegal_ff;
   assign mem_req_out       = req_ff;
   assign mem_addr_out      = maddr_ff;
   assign mem_single_out    = msingle_ff;
   assign freg_we_out       = fwe_ff;
   assign freg_addr_out     = faddr_ff;
   assign freg_data_out     = fdata_ff;
   assign ireg_we_out       = iwe_ff;
   assign ireg_addr_out     = iaddr_ff;
   assign ireg_data_out     = idata_ff;
   assign done_out          = done_ff;
endmodule // fp_load_decode_ea

// ==== fp_load_pkg.sv ====
// package for the floating-point load decoder: opcodes, fields, sizes, states
// assumes a 32-bit instruction word numbered from the lsb (bit 31 is the msb)
package fp_load_pkg;
   localparam logic [5:0] OP_PRIMARY_EXT  = 6'h1f;   // 31
   localparam logic [5:0] OP_LOAD_SINGLE  = 6'h30;   // 48
   localparam logic [5:0] OP_LOAD_SINGLE_U = 6'h31;  // 49
   localparam logic [9:0] XOP_LOAD_QUAD_X = 10'h317; // 791
   localparam logic [9:0] XOP_LOAD_SU_X   = 10'h237; // 567
   localparam int         PRIMARY_MSB     = 31;
   localparam int         TARGET_LSB      = 21;
   localparam int         BASE_LSB        = 16;
   localparam int         INDEX_LSB       = 11;
   localparam int         XOP_LSB         = 1;
   localparam logic [31:0] QUAD_SECOND_OFS = 32'h0000_0008;
   localparam logic [4:0]  LAST_FREG       = 5'h1f;
   localparam logic [10:0] SINGLE_EXP_BIAS_ADJ = 11'h380; // 1023 - 127

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_FIRST = 4'b0010,
      ST_SECOND = 4'b0100,
      ST_DONE  = 4'b1000
   } load_state_type;

   typedef enum logic [1:0] {
      K_QUAD_X  = 2'h0,
      K_SINGLE  = 2'h1,
      K_SINGLE_U = 2'h2,
      K_SINGLE_UX = 2'h3
   } load_kind_type;
endpackage

// ==== fp_load_mem_if.sv ====
// interface between the decoder sequencer and the single-to-double widener
// assumes both ends run on the core clock
`timescale 1ns/1ps
interface fp_load_mem_if;
   logic [31:0] single_word;
   logic [63:0] double_word;
   modport widen_side (input single_word, output double_word);
   modport user_side  (output single_word, input double_word);
endinterface

// ==== fp_single_widen.sv ====
// combinational widening of a single-precision word to double precision
// assumes the caller registers the result; denormal inputs are normalised
`timescale 1ns/1ps
module fp_single_widen
   import fp_load_pkg::*;
(
   fp_load_mem_if.widen_side cvt
);
   // -------------------------------------------------------------
   // widening
   // -------------------------------------------------------------
   logic        sgn;
   logic [7:0]  exp_s;
   logic [22:0] frac_s;
   logic [10:0] exp_d;
   logic [51:0] frac_d;
   logic [4:0]  lead;
   logic [22:0] shifted;

   // exponent rebias; all-ones exponent keeps inf/nan; nonzero denormals renormalise
   always_comb begin
      sgn     = cvt.single_word[31];
      exp_s   = cvt.single_word[30:23];
      frac_s  = cvt.single_word[22:0];
      lead    = 5'h00;
      shifted = frac_s;
      exp_d   = 11'h000;
      frac_d  = {frac_s, 29'h0};
      if (exp_s == 8'hff) begin
         exp_d = 11'h7ff;
      end else if (exp_s != 8'h00) begin
         exp_d = {3'h0, exp_s} + SINGLE_EXP_BIAS_ADJ;
      end else if (frac_s != 23'h0) begin
         // shift the fraction until its leading one falls off the top
         for (int i = 22; i >= 0; i--) begin
            if (frac_s[i] && lead == 5'h00 && shifted == frac_s) begin
               lead    = 5'(22 - i);
               shifted = 23'(frac_s << (23 - i));
            end
         end
         exp_d  = SINGLE_EXP_BIAS_ADJ + 11'h001 - {6'h0, lead} - 11'h001;
         frac_d = {shifted, 29'h0};
      end
      cvt.double_word = {sgn, exp_d, frac_d};
   end
endmodule // fp_single_widen

// ==== fp_load_assertions.sv ====
// checker for the float load decoder, bound onto its top module
// assumes one core clock and an active-low asynchronous reset
`timescale 1ns/1ps
module fp_load_assertions (
   input wire logic        sys_clk_in,
   input wire logic        rstn_in,
   input wire logic        instr_valid_in,
   input wire logic        mem_data_valid_in,
   input wire logic        mem_fault_in,
   input wire logic        instr_ready_out,
   input wire logic        instr_illegal_out,
   input wire logic        mem_req_out,
   input wire logic [31:0] mem_addr_out,
   input wire logic        mem_single_out,
   input wire logic        freg_we_out,
   input wire logic [4:0]  freg_addr_out,
   input wire logic        ireg_we_out,
   input wire logic [4:0]  ireg_addr_out,
   input wire logic [31:0] ireg_data_out,
   input wire logic        done_out
);
   default clocking dc @(posedge sys_clk_in); endclocking
   default disable iff (!rstn_in);
   logic [31:0] last_addr_ff;
   logic [31:0] nxt_last_addr;
   // ----------------------------------------------------------
   // helper: address of the previous request
   // ----------------------------------------------------------
   always_comb nxt_last_addr = mem_req_out ? mem_addr_out : last_addr_ff;
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in)
         last_addr_ff <= 32'h0000_0000;
      else
         last_addr_ff <= nxt_last_addr;
   end
   // ----------------------------------------------------------
   // properties
   // ----------------------------------------------------------
   // a taken word either starts a read or is answered as illegal, never both
   a_ready_starts_req: assert property (instr_ready_out |-> $past(instr_valid_in)
      && (mem_req_out ^ instr_illegal_out) ##1 !instr_ready_out)
      else $error("ready without request");
   a_second_half_ofs: assert property (mem_req_out && !instr_ready_out
      |-> mem_addr_out == last_addr_ff + 32'h0000_0008) else $error("second address");
   a_pair_next_reg: assert property (freg_we_out && $past(freg_we_out)
      |-> freg_addr_out == $past(freg_addr_out) + 5'h01) else $error("pair register");
   a_quad_pair_done: assert property (freg_we_out && !mem_single_out && !done_out
      |=> freg_we_out && done_out) else $error("quad second write");
   a_single_result: assert property (mem_data_valid_in && mem_single_out
      |=> freg_we_out && done_out) else $error("single result late");
   a_update_value: assert property (ireg_we_out
      |-> ireg_addr_out != 5'h00 && ireg_data_out == mem_addr_out) else $error("write-back");
   a_fault_quiet: assert property (mem_fault_in
      |=> (!freg_we_out && !ireg_we_out)[*2]) else $error("write after fault");
   a_fault_done: assert property (mem_fault_in |-> ##[1:2] done_out)
      else $error("fault not finished");
   a_write_cause: assert property (freg_we_out
      |-> $past(mem_data_valid_in) || $past(freg_we_out)) else $error("write without data");
endmodule // fp_load_assertions

bind fp_load_decode_ea fp_load_assertions fp_load_assertions_i (
   .sys_clk_in, .rstn_in, .instr_valid_in, .mem_data_valid_in, .mem_fault_in,
   .instr_ready_out, .instr_illegal_out, .mem_req_out, .mem_addr_out, .mem_single_out,
   .freg_we_out, .freg_addr_out, .ireg_we_out, .ireg_addr_out, .ireg_data_out, .done_out
);

// ==== fp_load_port_model.sv ====
// behavioural memory load port answering the decoder's read requests
// assumes one request outstanding; single words come back in [31:0]
`timescale 1ns/1ps
module fp_load_port_model (
   input  wire logic        sys_clk_in,
   input  wire logic        rstn_in,
   input  wire logic        req_in,
   input  wire logic [31:0] addr_in,
   input  wire logic        single_in,
   input  wire logic [3:0]  delay_in,
   input  wire logic        fault_en_in,
   output logic             data_valid_out,
   output logic [63:0]      data_out,
   output logic             fault_out
);
   logic        pend;
   logic [3:0]  cnt;
   logic [1:0]  keep;
   logic [31:0] a;
   logic        s;
   // answer after delay_in idle cycles; data is inverted once its hold ends
   always @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pend           <= 1'b0;
         keep           <= 2'h0;
         data_valid_out <= 1'b0;
         fault_out      <= 1'b0;
         data_out       <= 64'h0;
      end else begin
         data_valid_out <= 1'b0;
         fault_out      <= 1'b0;
         if (keep == 2'h1)
            data_out <= ~data_out; // no stale value may pass for data
         if (keep != 2'h0)
            keep <= keep - 2'h1;
         if (req_in) begin
            pend <= 1'b1;
            cnt  <= delay_in;
            a    <= addr_in;
            s    <= single_in;
         end else if (pend && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
         end else if (pend) begin
            pend           <= 1'b0;
            keep           <= 2'h2;
            fault_out      <= fault_en_in;
            data_valid_out <= !fault_en_in;
            data_out <= s ? {~a, a[2] ? 32'h3f80_0000 : 32'hc000_0000} : {a, ~a};
         end
      end
   end
endmodule // fp_load_port_model

// ==== testbench.sv ====
// self-checking bench for the float load decoder
// assumes the load port model answers with address-derived data
`timescale 1ns/1ps
module testbench
   import fp_load_pkg::*;
;
   logic        clk = 1'b0, rstn = 1'b0, valid = 1'b0, flt = 1'b0, flt2 = 1'b0;
   logic [31:0] word = 32'h0, base_v = 32'h0, idx_v = 32'h0;
   logic [3:0]  dly = 4'h0;
   logic        dv, mfault, ready, ill_o, req, single, fwe, iwe, done, ill, sg;
   logic [63:0] mdata, fdata;
   logic [31:0] maddr, idata, id;
   logic [4:0]  faddr, iaddr, ia;
   logic [31:0] ra[$];
   logic [4:0]  fa[$];
   logic [63:0] fd[$];
   int          ni, miscompares = 0, checks = 0;
   always #5 clk = ~clk;

   fp_load_decode_ea fp_load_decode_ea_i (.sys_clk_in(clk), .rstn_in(rstn),
      .instr_valid_in(valid), .instr_word_in(word), .base_value_in(base_v),
      .index_value_in(idx_v), .mem_data_valid_in(dv), .mem_data_in(mdata),
      .mem_fault_in(mfault), .instr_ready_out(ready), .instr_illegal_out(ill_o),
      .mem_req_out(req), .mem_addr_out(maddr), .mem_single_out(single),
      .freg_we_out(fwe), .freg_addr_out(faddr), .freg_data_out(fdata),
      .ireg_we_out(iwe), .ireg_addr_out(iaddr), .ireg_data_out(idata), .done_out(done));
   fp_load_port_model fp_load_port_model_i (.sys_clk_in(clk), .rstn_in(rstn),
      .req_in(req), .addr_in(maddr), .single_in(single), .delay_in(dly),
      .fault_en_in(flt), .data_valid_out(dv), .data_out(mdata), .fault_out(mfault));

   task automatic chk(input logic c, input string m);
      checks++;
      if (c !== 1'b1) begin
         miscompares++;
         $display("Error at %0t ns: %s", $time, m);
      end
   endtask

   task automatic final_report;
      $display("checks %0d, miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // one instruction end to end; logs requests and writes until done
   task automatic run(input logic [31:0] w, b, x, input logic [3:0] d, input logic f);
      logic got;
      got = 1'b0;
      ra.delete(); fa.delete(); fd.delete(); ni = 0; ill = 1'b0;
      @(negedge clk);
      word <= w; base_v <= b; idx_v <= x; dly <= d; flt <= f; valid <= 1'b1;
      for (int n = 0; n < 80 && !got; n++) begin
         @(negedge clk);
         if (ready === 1'b1) valid <= 1'b0;
         if (req === 1'b1) begin
            ra.push_back(maddr);
            sg = single;
            // a quad's second answer may be made to fault on its own
            if (ra.size() == 2) flt <= flt2;
         end
         if (fwe === 1'b1) begin fa.push_back(faddr); fd.push_back(fdata); end
         if (iwe === 1'b1) begin ni++; ia = iaddr; id = idata; end
         if (ill_o === 1'b1) ill = 1'b1;
         got = (done === 1'b1);
      end
      if (!got) begin
         chk(1'b0, "no completion");
         final_report;
      end
   endtask

   task automatic t_disp;
      run({OP_LOAD_SINGLE, 5'h07, 5'h03, 16'hfffc}, 32'h0000_1000, 32'h0, 4'h0, 1'b0);
      chk(ra.size() == 1 && ra[0] === 32'h0000_0ffc, "disp address");
      chk(fa[0] === 5'h07 && fd[0] === 64'h3ff0_0000_0000_0000, "widening");
      chk(sg === 1'b1, "word read");
      chk(ni == 0 && ill === 1'b0 && fa.size() == 1, "stray write");
      run({OP_LOAD_SINGLE, 5'h1e, 5'h00, 16'h8000}, 32'h0000_0055, 32'h0, 4'h3, 1'b0);
      chk(ra[0] === 32'hffff_8000, "zero base address");
      chk(fa[0] === 5'h1e && fd[0] === 64'hc000_0000_0000_0000, "negative");
      $display("test disp done");
   endtask

   task automatic t_upd;
      run({OP_LOAD_SINGLE_U, 5'h02, 5'h05, 16'h0010}, 32'h0000_2000, 32'h0, 4'h1, 1'b0);
      chk(ra[0] === 32'h0000_2010 && fd[0] === 64'hc000_0000_0000_0000, "update");
      chk(ni == 1 && ia === 5'h05 && id === 32'h0000_2010, "write-back");
      run({OP_LOAD_SINGLE_U, 5'h02, 5'h00, 16'h0014}, 32'h0000_2000, 32'h0, 4'h0, 1'b0);
      chk(ni == 0 && ra[0] === 32'h0000_0014, "zero base update");
      run({OP_LOAD_SINGLE_U, 5'h02, 5'h05, 16'h0010}, 32'h0000_2000, 32'h0, 4'h2, 1'b1);
      chk(ni == 0 && fa.size() == 0, "fault write");
      $display("test update done");
   endtask

   task automatic t_updx;
      run({OP_PRIMARY_EXT, 15'h18a4, XOP_LOAD_SU_X, 1'b0}, 32'h100, 32'h24, 4'h0, 1'b0);
      chk(ra[0] === 32'h0000_0124 && fd[0] === 64'h3ff0_0000_0000_0000, "indexed");
      chk(ni == 1 && ia === 5'h05 && id === 32'h0000_0124, "indexed back");
      chk(fa.size() == 1 && ill === 1'b0, "indexed extra write");
      run({OP_PRIMARY_EXT, 15'h1804, XOP_LOAD_SU_X, 1'b0}, 32'h100, 32'h24, 4'h5, 1'b0);
      chk(ra[0] === 32'h0000_0024 && ni == 0, "zero base indexed");
      run({OP_PRIMARY_EXT, 15'h18a4, XOP_LOAD_SU_X, 1'b0}, 32'h100, 32'h24, 4'h1, 1'b1);
      chk(ni == 0 && fa.size() == 0, "indexed fault");
      $display("test indexed done");
   endtask

   task automatic t_quad;
      run({OP_PRIMARY_EXT, 15'h7c09, XOP_LOAD_QUAD_X, 1'b0}, 32'h77, 32'h3000, 4'h2, 1'b0);
      chk(ra.size() == 2 && ra[0] === 32'h3000 && ra[1] === 32'h3008, "pair addr");
      chk(fa.size() == 2 && fa[0] === 5'h1f && fa[1] === 5'h00, "wrap");
      chk(fd[0] === 64'h3000_ffff_cfff && fd[1] === 64'h3008_ffff_cff7, "pair");
      chk(ni == 0, "quad base write");
      chk(sg === 1'b0, "doubleword read");
      run({OP_PRIMARY_EXT, 15'h1069, XOP_LOAD_QUAD_X, 1'b0}, 32'h100, 32'h40, 4'h0, 1'b0);
      chk(ra[0] === 32'h0000_0140 && fa[1] === 5'h05, "based quad");
      run({OP_PRIMARY_EXT, 15'h1069, XOP_LOAD_QUAD_X, 1'b0}, 32'h100, 32'h40, 4'h0, 1'b1);
      chk(fa.size() == 0 && ni == 0, "quad fault");
      // fault on the second doubleword must cancel the held first write too
      flt2 = 1'b1;
      run({OP_PRIMARY_EXT, 15'h1069, XOP_LOAD_QUAD_X, 1'b0}, 32'h100, 32'h40, 4'h1, 1'b0);
      flt2 = 1'b0;
      chk(ra.size() == 2 && fa.size() == 0 && ni == 0, "second half fault");
      $display("test quad done");
   endtask

   task automatic t_illegal;
      run({OP_PRIMARY_EXT, 15'h0443, 10'h257, 1'b0}, 32'h100, 32'h40, 4'h0, 1'b0);
      chk(ill === 1'b1 && ra.size() == 0 && fa.size() == 0, "foreign opcode");
      $display("test illegal done");
   endtask

   initial begin
      repeat (6) @(negedge clk);
      rstn <= 1'b1;
      t_disp;
      t_upd;
      t_updx;
      t_quad;
      t_illegal;
      final_report;
   end
endmodule // testbench
